// ### verilog/esm_pkg.sv
package esm_pkg;

   // register indices; byte address is four times the index
   localparam logic [9:0]  ESM_IDX_EXT_CTRL = 10'h071;
   localparam logic [9:0]  ESM_IDX_SMM_CTRL = 10'h072;
   localparam logic [9:0]  ESM_IDX_TOM      = 10'h073;
   localparam logic [9:0]  ESM_IDX_IRQ_STAT = 10'h074;
   localparam logic [9:0]  ESM_IDX_IRQ_MASK = 10'h075;
   localparam int          ESM_AXI_AW       = 12;

   // extended control field positions
   localparam int          ESM_B_HIGH_EN    = 7;
   localparam int          ESM_B_ERR        = 6;
   localparam int          ESM_B_CACHE      = 5;
   localparam int          ESM_B_L1         = 4;
   localparam int          ESM_B_L2         = 3;
   localparam int          ESM_B_SZ_HI      = 2;
   localparam int          ESM_B_SZ_LO      = 1;
   localparam int          ESM_B_TOP_SEGMENT_ENABLE_BIT    = 0;
   localparam logic [7:0]  ESM_EXT_RESET    = 8'h00;

   // companion control field positions
   localparam int          ESM_B_OPEN       = 6;
   localparam int          ESM_B_LOCK       = 4;
   localparam int          ESM_B_GLOBAL     = 3;
   localparam logic [7:0]  ESM_SMM_RESET    = 8'h00;

   // top of memory in 128 KB units
   localparam int          ESM_TOM_W        = 11;
   localparam int          ESM_TOM_SHIFT    = 17;
   localparam logic [10:0] ESM_TOM_RESET    = 11'h000;

   // address map
   localparam logic [31:0] ESM_COMPAT_BASE  = 32'h000A_0000;
   localparam logic [31:0] ESM_COMPAT_LIMIT = 32'h000C_0000;
   localparam logic [31:0] ESM_HIGH_BASE    = 32'h100A_0000;
   localparam logic [31:0] ESM_HIGH_LIMIT   = 32'h100F_0000;
   localparam logic [31:0] ESM_TOP_MEMORY_SEGMENT_OFFSET  = 32'h1000_0000;
   localparam logic [31:0] ESM_TOP_MEMORY_SEGMENT_MIN     = 32'h0002_0000;
   localparam logic [31:0] ESM_ZERO_ADDR    = 32'h0000_0000;

   // bus responses
   localparam logic [1:0]  ESM_RESP_OKAY    = 2'b00;
   localparam logic [1:0]  ESM_RESP_SLVERR  = 2'b10;

   // host access as seen on the processor bus
   typedef struct packed {
      logic        ads;
      logic        smm_active_n;
      logic [31:0] addr;
   } esm_host_type;

   // routing decision, one per address strobe
   typedef struct packed {
      logic valid;
      logic to_dram;
      logic to_pci;
      logic smm_region;
      logic compat;
      logic uncacheable;
      logic l1_wb;
      logic l2_wb;
   } esm_decode_type;

endpackage

// ### verilog/esm_range_hit.sv
`timescale 1ns/1ps
`default_nettype none
// half-open address window compare
module esm_range_hit
(
   // window and address
   input  wire logic [31:0] base,
   input  wire logic [31:0] limit,
   input  wire logic [31:0] addr,
   // result
   output logic             hit
);
   // base inclusive, limit exclusive
   assign hit = (addr >= base) && (addr < limit);
endmodule
`default_nettype wire

// ### verilog/esm_decode.sv
// Function
// - bit 7 maps high region 100A0000h-100F0000h
// - non-SMM extended access sets error bit 6; code does not set it while open_en is set
// - error flag sticky, write one clears
// - cache strategy bit reads zero always
// - bit 4 allows first-level write-back caching
// - second-level caching needs bits 3 and 4
// - size field 128K, 256K, 512K, 1M
// - segment at 256MB plus top minus size
// - enabled segment forwards ordinary range to PCI
// - segment needs global and segment enable
// - compatible region below 1MB, uncacheable
// - extended regions cacheable write-back only
// - extended functions need global enable
// - open without lock shows SMM memory
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module esm_decode
(
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // axi4-lite write address and data
   input  wire logic [11:0]              s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0]              s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // host processor bus
   input  wire esm_pkg::esm_host_type    host,
   // routing to dram controller and pci path
   output esm_pkg::esm_decode_type       dec,
   // interrupt
   output logic                          irq
);
   import esm_pkg::*;

   // register state
   logic                high_en;
   logic                err_flag;
   logic                l1_en;
   logic                l2_en;
   logic [1:0]          top_segment_size_field;
   logic                top_segment_enable_bit;
   logic                global_en;
   logic                open_en;
   logic                lock;
   logic [ESM_TOM_W-1:0] top_of_memory;
   logic                irq_stat;
   logic                irq_mask;

   // bus channel state
   logic                aw_held;
   logic                w_held;
   logic [9:0]          aw_idx;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                wr_go;
   logic                wr_ok;
   logic                rd_ok;
   logic [9:0]          ar_idx;
   logic [31:0]         next_rdata;

   // decode terms
   logic                smm_mode;
   logic                smm_visible;
   logic                ext_on;
   logic                top_memory_segment_on;
   logic [31:0]         tom_bytes;
   logic [31:0]         top_memory_segment_size;
   logic [31:0]         ord_base;
   logic [31:0]         seg_base;
   logic [31:0]         seg_limit;
   logic                hit_compat;
   logic                hit_high;
   logic                hit_seg;
   logic                hit_ord;
   logic                hit_dram;
   logic                err_event;
   logic                err_clear;
   esm_decode_type      next_dec;

   // address windows
   esm_range_hit u_compat
   (
      .base  (ESM_COMPAT_BASE),
      .limit (ESM_COMPAT_LIMIT),
      .addr  (host.addr),
      .hit   (hit_compat)
   );
   esm_range_hit u_high
   (
      .base  (ESM_HIGH_BASE),
      .limit (ESM_HIGH_LIMIT),
      .addr  (host.addr),
      .hit   (hit_high)
   );
   esm_range_hit u_seg
   (
      .base  (seg_base),
      .limit (seg_limit),
      .addr  (host.addr),
      .hit   (hit_seg)
   );
   esm_range_hit u_ord
   (
      .base  (ord_base),
      .limit (tom_bytes),
      .addr  (host.addr),
      .hit   (hit_ord)
   );
   esm_range_hit u_dram
   (
      .base  (ESM_ZERO_ADDR),
      .limit (tom_bytes),
      .addr  (host.addr),
      .hit   (hit_dram)
   );

   // segment geometry
   assign tom_bytes = {{(32-ESM_TOM_W-ESM_TOM_SHIFT){1'b0}}, top_of_memory, {ESM_TOM_SHIFT{1'b0}}};
   assign top_memory_segment_size = ESM_TOP_MEMORY_SEGMENT_MIN << top_segment_size_field;
   assign ord_base  = tom_bytes - top_memory_segment_size;
   assign seg_base  = ESM_TOP_MEMORY_SEGMENT_OFFSET + tom_bytes - top_memory_segment_size;
   assign seg_limit = ESM_TOP_MEMORY_SEGMENT_OFFSET + tom_bytes;

   // mode and enables
   assign smm_mode    = host.ads && !host.smm_active_n;
   assign smm_visible = smm_mode || (open_en && !lock);
   assign ext_on      = global_en;
   assign top_memory_segment_on     = global_en && top_segment_enable_bit;
   assign err_event   = host.ads && !smm_mode && !open_en
                        && ((ext_on && high_en && hit_high)
                        || (top_memory_segment_on && hit_seg));

   // routing decision
   always_comb
   begin
      next_dec             = '0;
      next_dec.valid       = host.ads;
      next_dec.to_pci      = host.ads;
      if (host.ads && global_en && hit_compat)
      begin
         next_dec.compat      = 1'b1;
         next_dec.smm_region  = 1'b1;
         next_dec.uncacheable = 1'b1;
         next_dec.to_dram     = smm_visible;
         next_dec.to_pci      = !smm_visible;
      end
      else if (host.ads && ext_on && high_en && hit_high)
      begin
         next_dec.smm_region = 1'b1;
         next_dec.to_dram    = smm_visible;
         next_dec.to_pci     = !smm_visible;
         next_dec.l1_wb      = smm_visible && l1_en;
         next_dec.l2_wb      = smm_visible && l1_en && l2_en;
      end
      else if (host.ads && top_memory_segment_on && hit_seg)
      begin
         next_dec.smm_region = 1'b1;
         next_dec.to_dram    = smm_visible;
         next_dec.to_pci     = !smm_visible;
         next_dec.l1_wb      = smm_visible && l1_en;
         next_dec.l2_wb      = smm_visible && l1_en && l2_en;
      end
      else if (host.ads && top_memory_segment_on && hit_ord)
      begin
         next_dec.to_pci  = 1'b1;
      end
      else if (host.ads && hit_dram)
      begin
         next_dec.to_dram = 1'b1;
         next_dec.to_pci  = 1'b0;
      end
   end

   // registered decode output
   always_ff @(posedge clk)
   begin
      if (rst)
         dec <= '0;
      else
         dec <= next_dec;
   end

   // write channel capture, either order
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_idx  <= '0;
         w_data  <= '0;
         w_strb  <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr[11:2];
         end
         else if (wr_go)
            aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (wr_go)
            w_held <= 1'b0;
      end
   end

   // ready while slot is free
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // write response
   assign wr_ok = (aw_idx == ESM_IDX_EXT_CTRL) || (aw_idx == ESM_IDX_SMM_CTRL)
                  || (aw_idx == ESM_IDX_TOM) || (aw_idx == ESM_IDX_IRQ_STAT)
                  || (aw_idx == ESM_IDX_IRQ_MASK);
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ESM_RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? ESM_RESP_OKAY : ESM_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // extended control register
   assign err_clear = wr_go && (aw_idx == ESM_IDX_EXT_CTRL) && w_strb[0]
                      && w_data[ESM_B_ERR];
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         high_en <= ESM_EXT_RESET[ESM_B_HIGH_EN];
         l1_en   <= ESM_EXT_RESET[ESM_B_L1];
         l2_en   <= ESM_EXT_RESET[ESM_B_L2];
         top_segment_size_field <= ESM_EXT_RESET[ESM_B_SZ_HI:ESM_B_SZ_LO];
         top_segment_enable_bit <= ESM_EXT_RESET[ESM_B_TOP_SEGMENT_ENABLE_BIT];
      end
      else if (wr_go && (aw_idx == ESM_IDX_EXT_CTRL) && w_strb[0])
      begin
         high_en <= w_data[ESM_B_HIGH_EN];
         l1_en   <= w_data[ESM_B_L1];
         l2_en   <= w_data[ESM_B_L2];
         top_segment_size_field <= w_data[ESM_B_SZ_HI:ESM_B_SZ_LO];
         top_segment_enable_bit <= w_data[ESM_B_TOP_SEGMENT_ENABLE_BIT];
      end
   end

   // sticky error flag, set beats clear
   always_ff @(posedge clk)
   begin
      if (rst)
         err_flag <= ESM_EXT_RESET[ESM_B_ERR];
      else
         err_flag <= err_event || (err_flag && !err_clear);
   end

   // companion control: global, open, lock
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         global_en <= ESM_SMM_RESET[ESM_B_GLOBAL];
         open_en   <= ESM_SMM_RESET[ESM_B_OPEN];
         lock      <= ESM_SMM_RESET[ESM_B_LOCK];
      end
      else if (wr_go && (aw_idx == ESM_IDX_SMM_CTRL) && w_strb[0])
      begin
         global_en <= w_data[ESM_B_GLOBAL];
         lock      <= lock || w_data[ESM_B_LOCK];
         open_en   <= !(lock || w_data[ESM_B_LOCK]) && w_data[ESM_B_OPEN];
      end
   end

   // top of memory and interrupt mask registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         top_of_memory      <= ESM_TOM_RESET;
         irq_mask <= 1'b0;
      end
      else if (wr_go && (aw_idx == ESM_IDX_TOM))
      begin
         if (w_strb[0])
            top_of_memory[7:0] <= w_data[7:0];
         if (w_strb[1])
            top_of_memory[ESM_TOM_W-1:8] <= w_data[ESM_TOM_W-1:8];
      end
      else if (wr_go && (aw_idx == ESM_IDX_IRQ_MASK) && w_strb[0])
         irq_mask <= w_data[0];
   end

   // interrupt status, write one clears, event wins
   always_ff @(posedge clk)
   begin
      if (rst)
         irq_stat <= 1'b0;
      else
         irq_stat <= err_event || (irq_stat && !(wr_go
                     && (aw_idx == ESM_IDX_IRQ_STAT) && w_strb[0] && w_data[0]));
   end

   // level interrupt
   always_ff @(posedge clk)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= irq_stat && irq_mask;
   end

   // read data select
   always_comb
   begin
      next_rdata = '0;
      rd_ok      = 1'b1;
      case (s_axi_araddr[11:2])
         ESM_IDX_EXT_CTRL: next_rdata[7:0] = {high_en, err_flag, 1'b0, l1_en,
                                              l2_en, top_segment_size_field, top_segment_enable_bit};
         ESM_IDX_SMM_CTRL: next_rdata[7:0] = {1'b0, open_en, 1'b0, lock,
                                              global_en, 3'b000};
         ESM_IDX_TOM:      next_rdata[ESM_TOM_W-1:0] = top_of_memory;
         ESM_IDX_IRQ_STAT: next_rdata[0] = irq_stat;
         ESM_IDX_IRQ_MASK: next_rdata[0] = irq_mask;
         default:          rd_ok = 1'b0;
      endcase
   end

   // read channel, one outstanding
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= ESM_RESP_OKAY;
         ar_idx        <= '0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= rd_ok ? ESM_RESP_OKAY : ESM_RESP_SLVERR;
         ar_idx        <= s_axi_araddr[11:2];
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else
         s_axi_arready <= 1'b1;
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_HIGH_DRAM: assert property (
      host.ads && hit_high && global_en && high_en && !host.smm_active_n
      |=> dec.to_dram && dec.smm_region)
      else $error("high region not routed to dram in smm");
   AST_HIGH_OFF: assert property (
      host.ads && hit_high && !(global_en && high_en) |=> !dec.smm_region)
      else $error("high region decoded while disabled");
   AST_ERR_SET: assert property (
      err_event |=> err_flag && irq_stat)
      else $error("error event not latched");
   AST_ERR_HOLD: assert property (
      err_flag && !err_clear |=> err_flag)
      else $error("error flag dropped without clear");
   AST_ERR_CLEAR: assert property (
      err_flag && err_clear && !err_event |=> !err_flag)
      else $error("error flag not cleared by write one");
   AST_CACHE_ZERO: assert property (
      s_axi_rvalid && ar_idx == ESM_IDX_EXT_CTRL |-> !s_axi_rdata[ESM_B_CACHE])
      else $error("cache strategy bit read as one");
   AST_L2_NEEDS_L1: assert property (
      dec.l2_wb |-> dec.l1_wb && $past(l1_en))
      else $error("l2 caching without l1");
   AST_ORD_PCI: assert property (
      host.ads && top_memory_segment_on && hit_ord && !hit_compat
      |=> dec.to_pci && !dec.to_dram)
      else $error("top range still claimed by dram");
   AST_COMPAT_UC: assert property (
      dec.compat |-> dec.uncacheable && !dec.l1_wb && !dec.l2_wb)
      else $error("compatible region cacheable");
   AST_OPEN_VIS: assert property (
      host.ads && hit_compat && global_en && open_en && !lock |=> dec.to_dram)
      else $error("open override not honoured");
   AST_IRQ: assert property (
      irq_stat && irq_mask |=> irq)
      else $error("interrupt not raised");

   COV_ERR: cover property (err_event ##1 err_clear);
   COV_SEG: cover property (host.ads && top_memory_segment_on && hit_seg && smm_mode);
   COV_L2: cover property (dec.l2_wb);
   COV_READ: cover property (s_axi_rvalid && s_axi_rready);

endmodule
`default_nettype wire

// ### tb/esm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module esm_host_model
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // access request from the bench
   input  wire logic                 go,
   input  wire logic                 smm,
   input  wire logic [31:0]          addr,
   // processor bus
   output var  esm_pkg::esm_host_type host
);
   import esm_pkg::*;
   logic [31:0] last_addr;
   // remember lines so idle cycles can scramble them
   always_ff @(posedge clk)
      last_addr <= rst ? 32'h0000_0000 : host.addr;
   // smm state qualifies the strobe only; idle lines toggle
   always_comb
   begin
      host.ads          = go;
      host.smm_active_n = go ? ~smm : last_addr[0];
      host.addr         = go ? addr : ~last_addr;
   end
endmodule
`default_nettype wire

// ### tb/extended_smm_memory_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module extended_smm_memory_decode_tb_top;
   import esm_pkg::*;
   localparam logic [11:0] A_EXT  = {ESM_IDX_EXT_CTRL, 2'b00};
   localparam logic [11:0] A_SMM  = {ESM_IDX_SMM_CTRL, 2'b00};
   localparam logic [11:0] A_TOM  = {ESM_IDX_TOM, 2'b00};
   localparam logic [11:0] A_STAT = {ESM_IDX_IRQ_STAT, 2'b00};
   localparam logic [11:0] A_MASK = {ESM_IDX_IRQ_MASK, 2'b00};
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq, hgo, hsmm, stick;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, haddr, rd, a, sz, tomb, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic [7:0]  ext_v, smm_v;
   logic [10:0] tom_v;
   esm_host_type   host;
   esm_decode_type dec;
   integer bad_count, checks_done, seed, i, j;

   esm_decode dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .host(host), .dec(dec), .irq(irq));
   esm_host_model host_u (.clk(clk), .rst(rst), .go(hgo), .smm(hsmm), .addr(haddr),
      .host(host));

   // clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // closing report
   task summarize;
   begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   task ran_out;
   begin
      bad_count++;
      $display("Error at %0t: wait ran out got %h expected %h", $time, 0, 1);
      summarize;
   end
   endtask

   // axi4-lite write, address and data offered together
   task axi_wr(input logic [11:0] ad, input logic [31:0] d, output logic [1:0] r);
      integer n;
      logic aw, w, done;
   begin
      aw = 0; w = 0; done = 0; n = 0;
      @(posedge clk);
      awaddr <= ad; wdata <= d; wstrb <= 4'hF;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (aw && w && bvalid)
         begin
            r = bresp; bready <= 1'b0; done = 1;
         end
         if (!aw && awready)
         begin
            aw = 1; awvalid <= 1'b0;
         end
         if (!w && wready)
         begin
            w = 1; wvalid <= 1'b0;
         end
      end while (!done && n < 40);
      if (!done) ran_out;
   end
   endtask

   // axi4-lite read
   task axi_rd(input logic [11:0] ad, output logic [31:0] d, output logic [1:0] r);
      integer n;
      logic ar, done;
   begin
      ar = 0; done = 0; n = 0;
      @(posedge clk);
      araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (ar && rvalid)
         begin
            d = rdata; r = rresp; rready <= 1'b0; done = 1;
         end
         if (!ar && arready)
         begin
            ar = 1; arvalid <= 1'b0;
         end
      end while (!done && n < 40);
      if (!done) ran_out;
   end
   endtask

   // expected routing of one strobe under the current settings
   function automatic esm_decode_type exp_dec(input logic [31:0] ad, input logic sm,
                                              output logic e);
      logic g, vis, c, h, t, o;
      logic [31:0] tt, s;
      esm_decode_type d;
   begin
      g   = smm_v[ESM_B_GLOBAL];
      vis = sm | (smm_v[ESM_B_OPEN] & ~smm_v[ESM_B_LOCK]);
      tt  = {21'h0, tom_v} << ESM_TOM_SHIFT;
      s   = ESM_TOP_MEMORY_SEGMENT_MIN << ext_v[2:1];
      c = g && ad >= ESM_COMPAT_BASE && ad < ESM_COMPAT_LIMIT;
      h = g && ext_v[7] && ad >= ESM_HIGH_BASE && ad < ESM_HIGH_LIMIT;
      t = g && ext_v[0] && ad >= ESM_TOP_MEMORY_SEGMENT_OFFSET + tt - s && ad < ESM_TOP_MEMORY_SEGMENT_OFFSET + tt;
      o = g && ext_v[0] && ad >= tt - s && ad < tt;
      d = '0;
      d.valid = 1'b1;
      d.compat = c;
      d.uncacheable = c;
      d.smm_region = c | h | t;
      d.to_dram = (c | h | t) ? vis : (!o && ad < tt);
      d.to_pci = ~d.to_dram;
      d.l1_wb = (h | t) & vis & ext_v[ESM_B_L1];
      d.l2_wb = d.l1_wb & ext_v[ESM_B_L2];
      e = (h | t) & ~sm & ~smm_v[ESM_B_OPEN];
      return d;
   end
   endfunction

   // one host access, routing checked in the cycle after the strobe
   task host_acc(input logic [31:0] ad, input logic sm);
      logic e;
      esm_decode_type x;
   begin
      @(posedge clk);
      hgo <= 1'b1; haddr <= ad; hsmm <= sm;
      x = exp_dec(ad, sm, e);
      @(posedge clk);
      hgo <= 1'b0;
      @(posedge clk);
      chk({24'h0, dec}, {24'h0, x});
      if (x.compat) chk({31'h0, dec.uncacheable}, 32'h1);
      stick = stick | e;
      @(posedge clk);
      chk({24'h0, dec}, 32'h0);
   end
   endtask

   // main sequence
   initial
   begin
      seed = 49; bad_count = 0; checks_done = 0; stick = 0;
      rst = 1'b1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; hgo = 0; hsmm = 0; haddr = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 5; i++)
      begin
         axi_rd(A_EXT + 12'(4 * i), rd, rsp);
         chk(rd, 32'h0);
         chk({30'h0, rsp}, {30'h0, ESM_RESP_OKAY});
      end
      axi_rd(12'h1C0, rd, rsp);
      chk({rd[29:0], rsp}, {30'h0, ESM_RESP_SLVERR});
      axi_wr(12'h1C0, 32'hFF, rsp);
      chk({30'h0, rsp}, {30'h0, ESM_RESP_SLVERR});
      axi_wr(A_EXT, 32'hFF, rsp);
      axi_rd(A_EXT, rd, rsp);
      chk(rd, 32'h9F);
      $display("test registers done");
      axi_wr(A_MASK, 32'h1, rsp);
      for (i = 0; i < 40; i++)
      begin
         rv = $random(seed);
         ext_v = rv[7:0];
         smm_v = (rv[8] ? 8'h40 : 8'h00) | (i % 8 == 7 ? 8'h00 : 8'h08);
         tom_v = 11'(16 + {$random(seed)} % 240);
         axi_wr(A_EXT, {24'h0, ext_v}, rsp);
         axi_wr(A_SMM, {24'h0, smm_v}, rsp);
         axi_wr(A_TOM, {21'h0, tom_v}, rsp);
         sz = ESM_TOP_MEMORY_SEGMENT_MIN << ext_v[2:1];
         tomb = {21'h0, tom_v} << ESM_TOM_SHIFT;
         for (j = 0; j < 4; j++)
         begin
            rv = $random(seed);
            case (rv[2:0])
               3'd0: a = ESM_COMPAT_BASE + {$random(seed)} % 32'h2_0001;
               3'd1: a = ESM_HIGH_BASE - 1 + {$random(seed)} % 32'h5_0002;
               3'd2: a = ESM_TOP_MEMORY_SEGMENT_OFFSET + tomb - sz - 1 + {$random(seed)} % (sz + 2);
               3'd3: a = tomb - sz - 1 + {$random(seed)} % (sz + 2);
               3'd4: a = {$random(seed)} % tomb;
               default: a = $random(seed);
            endcase
            host_acc(a, rv[3]);
         end
         axi_rd(A_EXT, rd, rsp);
         chk(rd, {24'h0, ext_v & 8'h9F} | {25'h0, stick, 6'h0});
         chk({31'h0, irq}, {31'h0, stick});
         if (stick)
         begin
            axi_wr(A_EXT, {24'h0, ext_v & 8'hBF}, rsp);
            axi_rd(A_EXT, rd, rsp);
            chk({31'h0, rd[ESM_B_ERR]}, 32'h1);
            axi_wr(A_MASK, 32'h0, rsp);
            // irq is registered one edge after the mask lands
            @(posedge clk);
            chk({31'h0, irq}, 32'h0);
            axi_wr(A_MASK, 32'h1, rsp);
            axi_wr(A_EXT, {24'h0, ext_v | 8'h40}, rsp);
            axi_wr(A_STAT, 32'h1, rsp);
            stick = 0;
            axi_rd(A_EXT, rd, rsp);
            chk(rd, {24'h0, ext_v & 8'h9F});
            axi_rd(A_STAT, rd, rsp);
            chk(rd, 32'h0);
            chk({31'h0, irq}, 32'h0);
         end
      end
      $display("test decode done");
      axi_wr(A_SMM, 32'h58, rsp);
      axi_rd(A_SMM, rd, rsp);
      chk(rd, 32'h18);
      smm_v = 8'h18;
      ext_v = 8'h80;
      axi_wr(A_EXT, 32'h80, rsp);
      host_acc(ESM_HIGH_BASE, 1'b0);
      axi_rd(A_STAT, rd, rsp);
      chk(rd, 32'h1);
      $display("test lock done");
      summarize;
   end
endmodule
`default_nettype wire
